// File: tdc_pkg.sv
// Shared constants and types for the TDC data filter and event buffer
package tdc_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 5700;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);
  // Value range
  localparam logic [11:0] SLIDE_MAX = 12'hf00;
  // Register map, byte addresses
  localparam logic [15:0] BUF_LAST = 16'h0ffc;
  localparam logic [15:0] THR_BASE = 16'h1080;
  localparam logic [15:0] THR_LAST = 16'h10bf;
  localparam logic [15:0] CNT_LOW_ADDR = 16'h1100;
  localparam logic [15:0] CNT_HIGH_ADDR = 16'h1104;
  localparam logic [15:0] INC_EVENT_ADDR = 16'h1108;
  localparam logic [15:0] INC_WORD_ADDR = 16'h110c;
  localparam logic [15:0] STATUS_ADDR = 16'h1110;
  // Event layout
  localparam logic [5:0] FIRST_DATA = 6'h01;
  localparam logic [5:0] LAST_DATA = 6'h20;
  localparam int TYPE_LSB = 24;
  localparam int BIT_OVF = 12;
  localparam int BIT_UNDER = 13;
  localparam int BIT_INV = 14;
  localparam int KILL_BIT = 8;
  localparam logic [2:0] TYPE_HEADER = 3'h2;
  localparam logic [2:0] TYPE_DATA = 3'h0;
  localparam logic [2:0] TYPE_EOB = 3'h4;
  localparam logic [2:0] TYPE_NONE = 3'h6;
  // Status bits
  localparam int ST_READY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_EMPTY = 3;
  // Event fill sequencer, Gray along the usual path
  typedef enum logic [1:0] {
    IDLE = 2'h0,
    CONVERT = 2'h1,
    TRAILER = 2'h3,
    HEADER = 2'h2
  } fill_state_t;
endpackage : tdc_pkg

// File: tdc_filter_buffer.sv
// TDC data filter, event packing and multi-event buffer
`timescale 1ns/1ps
`default_nettype none
module tdc_filter_buffer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic data_reset,
  input wire logic common_pulse,
  input wire logic trigger_inhibit,
  input wire logic fast_abort,
  input wire logic conv_valid,
  input wire logic [4:0] conv_channel,
  input wire logic [11:0] conv_raw,
  input wire logic conv_overflow,
  input wire logic conv_invalid,
  input wire logic slide_enable,
  input wire logic [11:0] slide_offset,
  input wire logic threshold_step_select,
  input wire logic keep_under_threshold,
  input wire logic keep_overflow,
  input wire logic keep_invalid,
  input wire logic read_auto_advance,
  input wire logic store_empty_events,
  input wire logic count_all_triggers,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic busy,
  output logic data_ready,
  output logic buffer_full,
  output logic buffer_empty
);

  typedef struct packed {
    tdc_pkg::fill_state_t st;
    logic [6:0] timer;
    logic [4:0] wev;
    logic [5:0] wword;
    logic [4:0] rev;
    logic [5:0] rword;
    logic last_wr;
    logic [23:0] evcnt;
    logic [31:0] rdata;
    logic ack;
    logic busy;
    logic full;
    logic empty;
    logic drdy;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Words are addressed as {event, word}; 64 slots per event
  logic [31:0] buf_mem [0:2047];
  logic [8:0] thr_mem [0:31];

  logic mem_we;
  logic [10:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic thr_we;
  logic [4:0] thr_idx;
  logic [8:0] thr_wdata;
  logic [31:0] mem_rd;
  logic [8:0] thr_ent;
  logic [8:0] thr_bus;
  logic [11:0] corrected;
  logic slide_bad;
  logic invalid;
  logic under;
  logic keep;
  logic common_ok;
  logic in_buf;
  logic in_thr;
  logic rd_adv_ev;
  logic wr_adv;

  ////////////////////////////////////////////////////////////////
  // Filter path

  assign mem_rd = buf_mem[{s_q.rev, s_q.rword}];
  assign thr_ent = thr_mem[conv_channel];
  assign thr_bus = thr_mem[reg_addr[5:1]];

  // Offset added ahead of the converter is taken back here
  assign corrected = slide_enable ? conv_raw - slide_offset
                                  : conv_raw;
  assign slide_bad = slide_enable && (corrected > tdc_pkg::SLIDE_MAX);
  // Out-of-range slide results share the invalid flag
  assign invalid = conv_invalid || slide_bad;

  always_comb
  begin
    if (threshold_step_select)
    begin
      under = (corrected[11:9] == 3'h0)
           && (corrected[8:1] < thr_ent[7:0]);
    end
    else
    begin
      under = corrected[11:4] < thr_ent[7:0];
    end
  end

  assign keep = !thr_ent[tdc_pkg::KILL_BIT]
             && (!conv_overflow || keep_overflow)
             && (!invalid || keep_invalid)
             && (!under || keep_under_threshold);

  // A common is refused while converting or with the buffer full
  assign common_ok = common_pulse && !trigger_inhibit && !fast_abort
                  && (s_q.st == tdc_pkg::IDLE) && !s_q.full;

  assign in_buf = reg_addr <= tdc_pkg::BUF_LAST;
  assign in_thr = (reg_addr >= tdc_pkg::THR_BASE)
               && (reg_addr <= tdc_pkg::THR_LAST);

  ////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    mem_we = 1'b0;
    mem_waddr = {s_q.wev, s_q.wword};
    mem_wdata = 32'h0;
    thr_we = 1'b0;
    thr_idx = reg_addr[5:1];
    thr_wdata = reg_wdata[8:0];
    rd_adv_ev = 1'b0;
    wr_adv = 1'b0;

    if (common_pulse && (count_all_triggers || common_ok))
    begin
      s_d.evcnt = s_q.evcnt + 24'h1;
    end

    case (s_q.st)
      tdc_pkg::IDLE:
      begin
        if (common_ok)
        begin
          s_d.st = tdc_pkg::CONVERT;
          s_d.timer = tdc_pkg::CONV_LAST;
          s_d.wword = tdc_pkg::FIRST_DATA;
        end
      end
      tdc_pkg::CONVERT:
      begin
        if (fast_abort)
        begin
          // Aborted event leaves no trace in the buffer
          s_d.st = tdc_pkg::IDLE;
        end
        else
        begin
          if (conv_valid && keep && s_q.wword <= tdc_pkg::LAST_DATA)
          begin
            mem_we = 1'b1;
            mem_wdata = {5'h0, tdc_pkg::TYPE_DATA, 3'h0, conv_channel,
                         1'b0, invalid, under, conv_overflow,
                         corrected};
            s_d.wword = s_q.wword + 6'h1;
          end
          if (s_q.timer == 7'h0)
          begin
            if (s_d.wword != tdc_pkg::FIRST_DATA || store_empty_events)
            begin
              s_d.st = tdc_pkg::TRAILER;
            end
            else
            begin
              s_d.st = tdc_pkg::IDLE;
            end
          end
          else
          begin
            s_d.timer = s_q.timer - 7'h1;
          end
        end
      end
      tdc_pkg::TRAILER:
      begin
        mem_we = 1'b1;
        mem_wdata = {5'h0, tdc_pkg::TYPE_EOB, s_q.evcnt};
        s_d.st = tdc_pkg::HEADER;
      end
      tdc_pkg::HEADER:
      begin
        // Header goes last so the count of data words is known
        mem_we = 1'b1;
        mem_waddr = {s_q.wev, 6'h0};
        mem_wdata = {5'h0, tdc_pkg::TYPE_HEADER, 10'h0,
                     s_q.wword - 6'h1, 8'h0};
        s_d.wev = s_q.wev + 5'h1;
        wr_adv = 1'b1;
        s_d.st = tdc_pkg::IDLE;
      end
      default:
      begin
        s_d.st = tdc_pkg::IDLE;
      end
    endcase

    if (reg_rd)
    begin
      s_d.ack = 1'b1;
      if (in_buf)
      begin
        if (s_q.empty)
        begin
          s_d.rdata = {5'h0, tdc_pkg::TYPE_NONE, 24'h0};
        end
        else
        begin
          s_d.rdata = mem_rd;
          if (read_auto_advance)
          begin
            if (mem_rd[tdc_pkg::TYPE_LSB +: 3] == tdc_pkg::TYPE_EOB)
            begin
              rd_adv_ev = 1'b1;
            end
            else
            begin
              s_d.rword = s_q.rword + 6'h1;
            end
          end
        end
      end
      else if (in_thr)
      begin
        s_d.rdata = {23'h0, thr_bus};
      end
      else if (reg_addr == tdc_pkg::CNT_LOW_ADDR)
      begin
        s_d.rdata = {16'h0, s_q.evcnt[15:0]};
      end
      else if (reg_addr == tdc_pkg::CNT_HIGH_ADDR)
      begin
        s_d.rdata = {24'h0, s_q.evcnt[23:16]};
      end
      else if (reg_addr == tdc_pkg::STATUS_ADDR)
      begin
        s_d.rdata = 32'h0;
        s_d.rdata[tdc_pkg::ST_READY] = s_q.drdy;
        s_d.rdata[tdc_pkg::ST_FULL] = s_q.full;
        s_d.rdata[tdc_pkg::ST_BUSY] = s_q.busy;
        s_d.rdata[tdc_pkg::ST_EMPTY] = s_q.empty;
      end
      else
      begin
        s_d.rdata = 32'h0;
      end
    end
    else if (reg_wr)
    begin
      s_d.ack = 1'b1;
      if (in_thr)
      begin
        thr_we = 1'b1;
      end
      else if (reg_addr == tdc_pkg::INC_EVENT_ADDR)
      begin
        rd_adv_ev = 1'b1;
      end
      else if (reg_addr == tdc_pkg::INC_WORD_ADDR && !s_q.empty)
      begin
        s_d.rword = s_q.rword + 6'h1;
      end
    end

    // Reading past an empty buffer must not pull the pointer around
    if (rd_adv_ev && !s_q.empty)
    begin
      s_d.rev = s_q.rev + 5'h1;
      s_d.rword = 6'h0;
      s_d.last_wr = 1'b0;
    end
    if (wr_adv)
    begin
      s_d.last_wr = 1'b1;
    end

    if (data_reset)
    begin
      s_d.st = tdc_pkg::IDLE;
      s_d.wev = 5'h0;
      s_d.wword = 6'h0;
      s_d.rev = 5'h0;
      s_d.rword = 6'h0;
      s_d.last_wr = 1'b0;
      s_d.evcnt = 24'h0;
      mem_we = 1'b0;
    end

    s_d.full = (s_d.rev == s_d.wev) && s_d.last_wr;
    s_d.empty = (s_d.rev == s_d.wev) && !s_d.last_wr;
    s_d.drdy = !s_d.empty;
    s_d.busy = (s_d.st != tdc_pkg::IDLE) || s_d.full;
  end

  ////////////////////////////////////////////////////////////////
  // Storage

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.empty <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (mem_we && !reset)
    begin
      buf_mem[mem_waddr] <= mem_wdata;
    end
  end

  // No reset here: thresholds live until power is removed
  always_ff @(posedge sys_clk)
  begin
    if (thr_we)
    begin
      thr_mem[thr_idx] <= thr_wdata;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reg_ack = s_q.ack;
  assign busy = s_q.busy;
  assign data_ready = s_q.drdy;
  assign buffer_full = s_q.full;
  assign buffer_empty = s_q.empty;

  ////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || data_reset);

  sequence seq_close;
    s_q.st == tdc_pkg::TRAILER ##1 s_q.st == tdc_pkg::HEADER
      ##1 s_q.st == tdc_pkg::IDLE;
  endsequence

  AST_CONV_START: assert property (
    common_ok |=> s_q.st == tdc_pkg::CONVERT
      && s_q.timer == tdc_pkg::CONV_LAST)
    else $error("conversion window not started");

  AST_CONV_HOLD: assert property (
    s_q.st == tdc_pkg::CONVERT && s_q.timer != 7'h0 && !fast_abort
    |=> s_q.st == tdc_pkg::CONVERT
      && s_q.timer == $past(s_q.timer) - 7'h1)
    else $error("conversion window cut short");

  AST_EVENT_CLOSE: assert property (
    s_q.st == tdc_pkg::CONVERT && s_q.timer == 7'h0 && !fast_abort
      && s_q.wword != tdc_pkg::FIRST_DATA |=> seq_close)
    else $error("event not closed with trailer and header");

  AST_EMPTY_EVENT: assert property (
    s_q.st == tdc_pkg::CONVERT && s_q.timer == 7'h0 && !fast_abort
      && s_q.wword == tdc_pkg::FIRST_DATA && !conv_valid
      && !store_empty_events
    |=> s_q.st == tdc_pkg::IDLE && s_q.wev == $past(s_q.wev))
    else $error("empty event stored");

  AST_KILL: assert property (
    s_q.st == tdc_pkg::CONVERT && conv_valid
      && thr_ent[tdc_pkg::KILL_BIT] |-> !mem_we)
    else $error("killed channel stored");

  AST_OVERFLOW: assert property (
    s_q.st == tdc_pkg::CONVERT && conv_valid && conv_overflow
      && !keep_overflow |-> !mem_we)
    else $error("overflow stored");

  AST_INVALID: assert property (
    s_q.st == tdc_pkg::CONVERT && conv_valid && invalid
      && !keep_invalid |-> !mem_we)
    else $error("invalid datum stored");

  AST_UNDER_FLAG: assert property (
    s_q.st == tdc_pkg::CONVERT && mem_we
    |-> mem_wdata[tdc_pkg::BIT_UNDER] == under
      && (keep_under_threshold || !under))
    else $error("under-threshold handling wrong");

  AST_NOT_EMPTY: assert property (
    s_q.rev != s_q.wev |-> s_q.drdy && !s_q.empty && !s_q.full)
    else $error("differing pointers not reported");

  AST_FULL_EMPTY: assert property (
    s_q.rev == s_q.wev
    |-> s_q.full == s_q.last_wr && s_q.empty == !s_q.last_wr)
    else $error("full or empty wrong");

  AST_BUSY_FULL: assert property (
    s_q.full |-> s_q.busy && !common_ok)
    else $error("full buffer not busy");

  AST_COUNT_ALL: assert property (
    count_all_triggers && common_pulse
    |=> s_q.evcnt == $past(s_q.evcnt) + 24'h1)
    else $error("common pulse not counted");

  AST_WPTR: assert property (
    s_q.st == tdc_pkg::HEADER
    |=> s_q.wev == $past(s_q.wev) + 5'h1 && s_q.last_wr)
    else $error("write pointer not advanced");

  AST_READ_WIN: assert property (
    reg_rd && in_buf && !s_q.empty
    |=> reg_ack && reg_rdata == $past(mem_rd))
    else $error("buffer read wrong word");

  AST_CNT_LOW: assert property (
    reg_rd && reg_addr == tdc_pkg::CNT_LOW_ADDR
    |=> reg_rdata == {16'h0, $past(s_q.evcnt[15:0])})
    else $error("count low register wrong");

endmodule : tdc_filter_buffer
`default_nettype wire

// File: bus_master.sv
// Register bus master that reads events out of the filter buffer
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input wire logic sys_clk,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  output var logic [15:0] reg_addr,
  output var logic reg_wr,
  output var logic reg_rd,
  output var logic [31:0] reg_wdata
);
  initial
  begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////
  // Strobe lasts one cycle: held longer, an auto-advancing read is taken
  // twice. Address and data stay until the ack, then show their inverse.
  task automatic xfer(input logic wr, input logic [15:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata, output bit ok);
    ok = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_wdata <= wdata;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge sys_clk);
      if (reg_ack === 1'b1)
      begin
        ok = 1'b1;
        rdata = reg_rdata;
      end
    end
    reg_addr <= ~addr;
    reg_wdata <= ~wdata;
  endtask : xfer
endmodule : bus_master
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the TDC filter and event buffer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic data_reset = 1'b0;
  logic common_pulse = 1'b0;
  logic trigger_inhibit = 1'b0;
  logic fast_abort = 1'b0;
  logic conv_valid = 1'b0;
  logic [4:0] conv_channel = 5'h00;
  logic [11:0] conv_raw = 12'h000;
  logic conv_overflow = 1'b0;
  logic conv_invalid = 1'b0;
  logic slide_enable = 1'b0;
  logic [11:0] slide_offset = 12'h010;
  logic threshold_step_select = 1'b0;
  logic keep_under_threshold = 1'b0;
  logic keep_overflow = 1'b0;
  logic keep_invalid = 1'b0;
  logic read_auto_advance = 1'b0;
  logic store_empty_events = 1'b0;
  logic count_all_triggers = 1'b1;
  logic [15:0] reg_addr;
  logic reg_wr, reg_rd, reg_ack, busy, data_ready;
  logic buffer_full, buffer_empty;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [23:0] ev_cnt = 24'h000000;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 sys_clk = ~sys_clk;
  tdc_filter_buffer uut (.sys_clk, .reset, .data_reset, .common_pulse,
    .trigger_inhibit, .fast_abort, .conv_valid, .conv_channel, .conv_raw,
    .conv_overflow, .conv_invalid, .slide_enable, .slide_offset,
    .threshold_step_select, .keep_under_threshold, .keep_overflow,
    .keep_invalid, .read_auto_advance, .store_empty_events,
    .count_all_triggers, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_ack, .busy, .data_ready, .buffer_full, .buffer_empty);
  bus_master m (.sys_clk, .reg_ack, .reg_rdata, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata);
  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] mask);
    total_checks++;
    if ((got & mask) !== (exp & mask))
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang(input bit ok);
    if (!ok)
    begin
      error_cnt++;
      $display("Error %0t: no answer from block", $time);
      wrap_up();
    end
  endtask : hang
  task automatic rd(input logic [15:0] a, input logic [31:0] exp,
    input logic [31:0] mask);
    bit ok;
    m.xfer(1'b0, a, 32'h0, d, ok);
    hang(ok);
    chk(d, exp, mask);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    bit ok;
    m.xfer(1'b1, a, v, d, ok);
    hang(ok);
  endtask : wr
  // Full, empty and ready seen together so a stale flag shows up
  task automatic flags(input logic full, input logic empty);
    chk({29'h0, buffer_full, buffer_empty, data_ready},
      {29'h0, full, empty, !empty}, 32'h7);
  endtask : flags
  task automatic common(input logic counted);
    @(posedge sys_clk);
    common_pulse <= 1'b1;
    @(posedge sys_clk);
    common_pulse <= 1'b0;
    ev_cnt = ev_cnt + 24'(counted);
  endtask : common
  task automatic conv(input logic [4:0] ch, input logic [11:0] raw,
    input logic ovf, input logic inv);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_channel <= ch;
    conv_raw <= raw;
    conv_overflow <= ovf;
    conv_invalid <= inv;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
  endtask : conv
  task automatic wait_idle;
    int i;
    i = 0;
    repeat (4) @(posedge sys_clk);
    // A full buffer holds busy up after the event has closed
    while (busy !== 1'b0 && buffer_full !== 1'b1 && i < 300)
    begin
      @(posedge sys_clk);
      i++;
    end
    hang(i < 300);
    @(posedge sys_clk);
  endtask : wait_idle
  function automatic logic [31:0] dw(input logic [4:0] ch,
    input logic [2:0] f, input logic [11:0] v);
    return {8'h00, 3'h0, ch, 1'b0, f, v};
  endfunction : dw
  task automatic rd_hdr(input logic [5:0] n);
    rd(16'h0000, {16'h0200, 2'h0, n, 8'h00}, 32'h0700_3f00);
  endtask : rd_hdr
  task automatic rd_eob;
    rd(16'h0000, {8'h04, ev_cnt}, 32'h07ff_ffff);
  endtask : rd_eob
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_thresholds;
    flags(1'b0, 1'b1);
    rd(16'h0000, 32'h0600_0000, 32'hffff_ffff);
    rd(16'h2000, 32'h0, 32'hffff_ffff);
    for (int ch = 0; ch < 32; ch++)
      wr(tdc_pkg::THR_BASE + 16'(2 * ch), (ch == 3) ? 32'h110 : 32'h010);
    rd(16'h1086, 32'h110, 32'h1ff);
  endtask : t_reset_and_thresholds
  // Coarse step, flagged data dropped, pointer moved by hand
  task automatic t_filter_manual;
    common(1'b1);
    conv(5'd0, 12'h100, 1'b0, 1'b0);
    conv(5'd1, 12'h0ff, 1'b0, 1'b0);
    conv(5'd2, 12'h200, 1'b1, 1'b0);
    conv(5'd3, 12'h300, 1'b0, 1'b0);
    conv(5'd4, 12'h400, 1'b0, 1'b1);
    wait_idle();
    flags(1'b0, 1'b0);
    rd_hdr(6'd1);
    rd(16'h0ffc, 32'h0200_0100, 32'h0700_3f00);
    wr(tdc_pkg::INC_WORD_ADDR, 32'h0);
    rd(16'h0040, dw(5'd0, 3'h0, 12'h100), 32'h071f_7fff);
    wr(tdc_pkg::INC_WORD_ADDR, 32'h0);
    rd_eob();
    wr(tdc_pkg::INC_EVENT_ADDR, 32'h0);
    flags(1'b0, 1'b1);
  endtask : t_filter_manual
  // Fine step, slide on, flagged data kept, killed channel dropped, auto advance
  task automatic t_filter_keep;
    slide_enable <= 1'b1;
    threshold_step_select <= 1'b1;
    keep_under_threshold <= 1'b1;
    keep_overflow <= 1'b1;
    keep_invalid <= 1'b1;
    read_auto_advance <= 1'b1;
    common(1'b1);
    conv(5'd5, 12'h01f, 1'b0, 1'b0);
    conv(5'd6, 12'h210, 1'b1, 1'b0);
    conv(5'd7, 12'hf20, 1'b0, 1'b0);
    conv(5'd8, 12'h300, 1'b0, 1'b1);
    conv(5'd9, 12'h030, 1'b0, 1'b0);
    conv(5'd3, 12'h800, 1'b0, 1'b0);
    wait_idle();
    rd_hdr(6'd5);
    rd(16'h0000, dw(5'd5, 3'h2, 12'h00f), 32'h071f_7fff);
    rd(16'h0000, dw(5'd6, 3'h1, 12'h200), 32'h071f_7fff);
    rd(16'h0000, dw(5'd7, 3'h4, 12'hf10), 32'h071f_7fff);
    rd(16'h0000, dw(5'd8, 3'h4, 12'h2f0), 32'h071f_7fff);
    rd(16'h0000, dw(5'd9, 3'h0, 12'h020), 32'h071f_7fff);
    rd_eob();
    flags(1'b0, 1'b1);
  endtask : t_filter_keep
  task automatic t_empty_and_refused;
    common(1'b1);
    wait_idle();
    flags(1'b0, 1'b1);
    store_empty_events <= 1'b1;
    common(1'b1);
    wait_idle();
    rd_hdr(6'd0);
    rd_eob();
    count_all_triggers <= 1'b0;
    trigger_inhibit <= 1'b1;
    common(1'b0);
    trigger_inhibit <= 1'b0;
    repeat (120) @(posedge sys_clk);
    flags(1'b0, 1'b1);
    common(1'b1);
    conv(5'd0, 12'h500, 1'b0, 1'b0);
    fast_abort <= 1'b1;
    @(posedge sys_clk);
    fast_abort <= 1'b0;
    wait_idle();
    flags(1'b0, 1'b1);
    rd(tdc_pkg::CNT_LOW_ADDR, {16'h0, ev_cnt[15:0]}, 32'hffff);
    rd(tdc_pkg::CNT_HIGH_ADDR, {24'h0, ev_cnt[23:16]}, 32'hff);
  endtask : t_empty_and_refused
  task automatic t_fill_and_clear;
    count_all_triggers <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      common(1'b1);
      wait_idle();
    end
    flags(1'b1, 1'b0);
    chk({31'h0, busy}, 32'h1, 32'h1);
    rd(tdc_pkg::STATUS_ADDR, 32'h0000_0007, 32'h0000_000f);
    common(1'b1);
    count_all_triggers <= 1'b0;
    common(1'b0);
    repeat (120) @(posedge sys_clk);
    rd(tdc_pkg::CNT_LOW_ADDR, {16'h0, ev_cnt[15:0]}, 32'hffff);
    rd_hdr(6'd0);
    @(posedge sys_clk);
    data_reset <= 1'b1;
    @(posedge sys_clk);
    data_reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    flags(1'b0, 1'b1);
    rd(tdc_pkg::STATUS_ADDR, 32'h0000_0008, 32'h0000_000f);
    rd(tdc_pkg::CNT_LOW_ADDR, 32'h0, 32'hffff);
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    rd(16'h1086, 32'h110, 32'h1ff);
  endtask : t_fill_and_clear
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset_and_thresholds();
    t_filter_manual();
    t_filter_keep();
    t_empty_and_refused();
    t_fill_and_clear();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
